// ==== rtl/anc_cfg.svh ====
// constants for the auto-negotiation strap and control block
`ifndef ANC_CFG_SVH
`define ANC_CFG_SVH
// register addresses
`define ANC_A_BMC     5'h00
`define ANC_A_BMS     5'h01
`define ANC_A_ADV     5'h04
`define ANC_A_LPA     5'h05
`define ANC_A_EXP     5'h06
`define ANC_A_SUM     5'h10
`define ANC_A_PHC     5'h19
// basic control bit positions
`define ANC_B_SPEED   13
`define ANC_B_ANEN    12
`define ANC_B_RESTART 9
`define ANC_B_DUPLEX  8
// phy control bit positions
`define ANC_B_MDIXEN  15
`define ANC_B_MDIXFRC 14
// ability nibble {100F,100H,10F,10H}, word bits [8:5]
`define ANC_ABIL_LSB  5
`define ANC_M_100F    4'h8
`define ANC_M_100H    4'h4
`define ANC_M_10F     4'h2
`define ANC_M_10H     4'h1
`define ANC_ABIL_ALL  4'hF
// fixed words
`define ANC_SELECTOR  5'h01
`define ANC_LP_PD100  16'h0081
`define ANC_LP_PD10   16'h0021
`define ANC_BMS_FIXED 16'h7849
`define ANC_LOCAL_NP  1'h1
// timing
`define ANC_BREAK_MS  1500
`define ANC_CLK_KHZ   200000
`define ANC_MDIX_SLOT 1000
`endif

// ==== rtl/anc_pkg.sv ====
// types shared by the auto-negotiation control block
package anc_pkg;
  typedef enum logic [4:0] {
    ST_LOAD    = 5'h01,
    ST_FORCED  = 5'h02,
    ST_BREAK   = 5'h04,
    ST_ABILITY = 5'h08,
    ST_LINK    = 5'h10
  } anc_state_e;
  typedef enum logic [4:0] {
    MI_IDLE = 5'h01,
    MI_ARM  = 5'h02,
    MI_HDR  = 5'h04,
    MI_TA   = 5'h08,
    MI_DATA = 5'h10
  } anc_mi_state_e;
  // line-side status from receivers and page decoder
  typedef struct packed {
    logic        flp_seen;
    logic        link_100;
    logic        link_10;
    logic        page_valid;
    logic [15:0] page_word;
  } anc_line_s;
  // one decoded management access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anc_mgmt_s;
endpackage

// ==== rtl/anc_mdio_slave.sv ====
// serial management frame slave for the control block
`timescale 1ns/1ps
`default_nettype none
module anc_mdio_slave
  import anc_pkg::*;
(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      reset_n_i,
  // management pins
  input  wire logic      mdc_i,
  input  wire logic      mdio_i,
  output logic           mdio_o,
  output logic           mdio_oe_o,
  // register side
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [15:0] rdata_i,
  output var anc_mgmt_s  mgmt_o
);
  anc_mi_state_e st_r;
  logic          mdc_q_r;
  logic          rise;
  logic          op_rd_r;
  logic [3:0]    cnt_r;
  logic [15:0]   sh_r;
  logic [15:0]   dout_r;
  logic [15:0]   nsh;
  anc_mgmt_s     m_r;

  assign rise   = mdc_i & ~mdc_q_r;
  assign nsh    = {sh_r[14:0], mdio_i};
  assign mgmt_o = m_r;

  // mdc edge detect; mdc is taken as synchronous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) mdc_q_r <= 1'b0;
    else mdc_q_r <= mdc_i;
  end

  // frame walker; preamble may be suppressed, one idle one suffices
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= MI_IDLE;
      op_rd_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 16'h0000;
      dout_r <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      m_r <= '0;
    end else begin
      m_r.rd <= 1'b0;
      m_r.wr <= 1'b0;
      if (rise) begin
        case (st_r)
          MI_IDLE: if (mdio_i) st_r <= MI_ARM;
          MI_ARM: if (!mdio_i) begin
            st_r <= MI_HDR;
            sh_r <= 16'h0000;
            cnt_r <= 4'h1;
          end
          MI_HDR: begin
            sh_r <= nsh;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'hD) begin
              cnt_r <= 4'h0;
              op_rd_r <= nsh[11:10] == 2'b10;
              m_r.addr <= nsh[4:0];
              // wrong start, opcode or address drops the frame
              if (nsh[13:12] == 2'b01 && nsh[9:5] == phy_addr_i &&
                  (nsh[11:10] == 2'b10 || nsh[11:10] == 2'b01))
                st_r <= MI_TA;
              else
                st_r <= MI_IDLE;
            end
          end
          MI_TA: begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0 && op_rd_r) begin
              // capture before the read side effects land
              dout_r <= rdata_i;
              m_r.rd <= 1'b1;
              mdio_o <= 1'b0;
              mdio_oe_o <= 1'b1;
            end
            if (cnt_r == 4'h1) begin
              st_r <= MI_DATA;
              cnt_r <= 4'h0;
              mdio_o <= dout_r[15];
              dout_r <= {dout_r[14:0], 1'b0};
            end
          end
          MI_DATA: begin
            cnt_r <= cnt_r + 4'h1;
            sh_r <= nsh;
            mdio_o <= dout_r[15];
            dout_r <= {dout_r[14:0], 1'b0};
            if (cnt_r == 4'hF) begin
              st_r <= MI_IDLE;
              mdio_oe_o <= 1'b0;
              m_r.wr <= ~op_rd_r;
              m_r.wdata <= nsh;
            end
          end
          default: st_r <= MI_IDLE;
        endcase
      end
    end
  end

  read_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    m_r.rd |-> mdio_oe_o && !mdio_o)
    else $error("read turnaround not driven low");
  cover_write_c: cover property (@(posedge clk_i) m_r.wr);
endmodule
`default_nettype wire

// ==== rtl/anc_core.sv ====
// auto-negotiation strap, resolution and management register core
`timescale 1ns/1ps
`default_nettype none
`include "anc_cfg.svh"
module anc_core
  import anc_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = `ANC_BREAK_MS * `ANC_CLK_KHZ,
  parameter int unsigned MDIX_SLOT    = `ANC_MDIX_SLOT
)(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      reset_n_i,
  // configuration straps
  input  wire logic      negotiate_strap_enable_i,
  input  wire logic      ability_select_high_i,
  input  wire logic      ability_select_low_i,
  input  wire logic      mdix_strap_i,
  input  wire logic [4:0] phy_addr_strap_i,
  // line side
  input  wire anc_line_s line_i,
  output logic           flp_send_o,
  output logic           tx_quiet_o,
  output logic [15:0]    adv_word_o,
  output logic           link_up_o,
  output logic           speed_100_o,
  output logic           full_duplex_o,
  output logic           mdi_swap_o,
  // management pins
  input  wire logic      mdc_i,
  input  wire logic      mdio_i,
  output logic           mdio_o,
  output logic           mdio_oe_o
);
  localparam logic [31:0] BRK_LAST  = 32'(BREAK_CYCLES - 1);
  localparam logic [31:0] SLOT_LAST = 32'(MDIX_SLOT - 1);

  if (BREAK_CYCLES < 1 || MDIX_SLOT < 1) begin : g_chk
    $error("timer counts must be at least one");
  end

  anc_state_e  state_r;
  anc_mgmt_s   mg;
  logic [15:0] rdata;
  logic        ctl_speed_r, ctl_aneg_r, ctl_duplex_r, an_block_r;
  logic [3:0]  adv_r, res_r, common, pick, mode, strap_adv;
  logic [15:0] lp_r;
  logic        pd_fault_r, page_rx_r, partner_an_r;
  logic        mdix_en_r, mdix_force_r, swap_r;
  logic [4:0]  phy_addr_r;
  logic [31:0] brk_cnt_r, slot_cnt_r;
  logic [7:0]  lfsr_r;
  logic        aneg_eff, restart, pd_ok, pd_bad, cur_link, mdix_act;
  logic        wr_bmc, wr_adv, wr_phc, rd_exp;

  anc_mdio_slave u_mdio (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .mdc_i      (mdc_i),
    .mdio_i     (mdio_i),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o),
    .phy_addr_i (phy_addr_r),
    .rdata_i    (rdata),
    .mgmt_o     (mg)
  );

  // decoded management strobes
  assign wr_bmc = mg.wr && mg.addr == `ANC_A_BMC;
  assign wr_adv = mg.wr && mg.addr == `ANC_A_ADV;
  assign wr_phc = mg.wr && mg.addr == `ANC_A_PHC;
  assign rd_exp = mg.rd && mg.addr == `ANC_A_EXP;
  assign restart = wr_bmc && mg.wdata[`ANC_B_RESTART];
  assign aneg_eff = ctl_aneg_r && !an_block_r;

  always_comb begin
    case ({ability_select_high_i, ability_select_low_i})
      2'b00:   strap_adv = `ANC_M_10F | `ANC_M_10H;
      2'b01:   strap_adv = `ANC_M_100F | `ANC_M_100H;
      2'b10:   strap_adv = `ANC_M_100H | `ANC_M_10H;
      default: strap_adv = `ANC_ABIL_ALL;
    endcase
  end

  assign common = adv_r & line_i.page_word[8:5];
  always_comb begin
    if (common[3])      pick = `ANC_M_100F;
    else if (common[2]) pick = `ANC_M_100H;
    else if (common[1]) pick = `ANC_M_10F;
    else                pick = `ANC_M_10H;
  end

  assign pd_ok  = !line_i.flp_seen && (line_i.link_100 ^ line_i.link_10);
  assign pd_bad = !line_i.flp_seen && line_i.link_100 && line_i.link_10;

  // speed/duplex bits count in every state but ST_LINK
  always_comb begin
    if (state_r == ST_LINK) mode = res_r;
    else if (ctl_speed_r) mode = ctl_duplex_r ? `ANC_M_100F : `ANC_M_100H;
    else mode = ctl_duplex_r ? `ANC_M_10F : `ANC_M_10H;
  end
  assign cur_link = |mode[3:2] ? line_i.link_100 : line_i.link_10;

  // basic control; straps land in the first cycle after release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_speed_r <= 1'b0;
      ctl_aneg_r <= 1'b0;
      ctl_duplex_r <= 1'b0;
      an_block_r <= 1'b0;
    end else if (state_r == ST_LOAD) begin
      ctl_aneg_r <= negotiate_strap_enable_i;
      an_block_r <= !negotiate_strap_enable_i;
      ctl_speed_r <= ability_select_high_i;
      ctl_duplex_r <= ability_select_low_i;
    end else if (wr_bmc) begin
      ctl_speed_r <= mg.wdata[`ANC_B_SPEED];
      ctl_aneg_r <= mg.wdata[`ANC_B_ANEN];
      ctl_duplex_r <= mg.wdata[`ANC_B_DUPLEX];
      // only a cleared enable lifts the gate
      if (!mg.wdata[`ANC_B_ANEN]) an_block_r <= 1'b0;
    end
  end

  // advertisement and phy control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adv_r <= `ANC_ABIL_ALL;
      mdix_en_r <= 1'b1;
      mdix_force_r <= 1'b0;
      phy_addr_r <= 5'h00;
    end else if (state_r == ST_LOAD) begin
      // straps into ability bits; forced keeps all
      adv_r <= negotiate_strap_enable_i ? strap_adv : `ANC_ABIL_ALL;
      mdix_en_r <= mdix_strap_i;
      phy_addr_r <= phy_addr_strap_i;
    end else begin
      if (wr_adv) adv_r <= mg.wdata[8:5];
      if (wr_phc) begin
        mdix_en_r <= mg.wdata[`ANC_B_MDIXEN];
        mdix_force_r <= mg.wdata[`ANC_B_MDIXFRC];
        phy_addr_r <= mg.wdata[4:0];
      end
    end
  end

  // negotiation sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_LOAD;
      res_r <= `ANC_M_10H;
    end else begin
      case (state_r)
        ST_LOAD: state_r <= negotiate_strap_enable_i ? ST_ABILITY
                                                     : ST_FORCED;
        ST_FORCED: if (aneg_eff) state_r <= ST_BREAK;
        ST_BREAK: begin
          if (!aneg_eff) state_r <= ST_FORCED;
          else if (brk_cnt_r == BRK_LAST) state_r <= ST_ABILITY;
        end
        ST_ABILITY: begin
          if (!aneg_eff) state_r <= ST_FORCED;
          else if (restart) state_r <= ST_BREAK;
          else if (line_i.page_valid && common != 4'h0) begin
            state_r <= ST_LINK;
            res_r <= pick;
          end else if (pd_ok) begin
            state_r <= ST_LINK;
            res_r <= line_i.link_100 ? `ANC_M_100H : `ANC_M_10H;
          end
        end
        ST_LINK: begin
          if (!aneg_eff) state_r <= ST_FORCED;
          else if (restart) state_r <= ST_BREAK;
          else if (!cur_link) state_r <= ST_ABILITY;
        end
        default: state_r <= ST_LOAD;
      endcase
    end
  end

  // break-link timer, only runs while quiet
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) brk_cnt_r <= 32'h0000_0000;
    else if (state_r != ST_BREAK) brk_cnt_r <= 32'h0000_0000;
    else brk_cnt_r <= brk_cnt_r + 32'h0000_0001;
  end

  // partner ability and expansion status
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lp_r <= 16'h0000;
      pd_fault_r <= 1'b0;
      page_rx_r <= 1'b0;
      partner_an_r <= 1'b0;
    end else begin
      // clear-on-read first, so a same-cycle event still sets
      if (rd_exp) begin
        pd_fault_r <= 1'b0;
        page_rx_r <= 1'b0;
      end
      if (state_r == ST_ABILITY && aneg_eff) begin
        if (line_i.page_valid) begin
          lp_r <= line_i.page_word;
          page_rx_r <= 1'b1;
          partner_an_r <= 1'b1;
        end else if (pd_ok) begin
          lp_r <= line_i.link_100 ? `ANC_LP_PD100 : `ANC_LP_PD10;
          partner_an_r <= 1'b0;
        end
        // two links at once is a fault
        if (pd_bad) pd_fault_r <= 1'b1;
      end
    end
  end

  // crossover hunt with a pseudo-random choice from a fixed seed while negotiating
  assign mdix_act = mdix_en_r && aneg_eff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfsr_r <= 8'hA5;
      slot_cnt_r <= 32'h0000_0000;
      swap_r <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      if (!mdix_act || state_r != ST_ABILITY) begin
        slot_cnt_r <= 32'h0000_0000;
      end else if (slot_cnt_r == SLOT_LAST) begin
        slot_cnt_r <= 32'h0000_0000;
        swap_r <= swap_r ^ lfsr_r[0];
      end else begin
        slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
      end
    end
  end

  // registered line-side outputs
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flp_send_o <= 1'b0;
      tx_quiet_o <= 1'b0;
      adv_word_o <= 16'h0000;
      link_up_o <= 1'b0;
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
      mdi_swap_o <= 1'b0;
    end else begin
      flp_send_o <= state_r == ST_ABILITY;
      // all transmit held off during break
      tx_quiet_o <= state_r == ST_BREAK;
      adv_word_o <= {7'h00, adv_r, `ANC_SELECTOR};
      link_up_o <= (state_r == ST_LINK || state_r == ST_FORCED) && cur_link;
      speed_100_o <= |mode[3:2];
      full_duplex_o <= mode[3] | mode[1];
      mdi_swap_o <= mdix_force_r || (mdix_act && swap_r);
    end
  end

  // management read data
  always_comb begin
    case (mg.addr)
      `ANC_A_BMC: rdata = {2'b00, ctl_speed_r, ctl_aneg_r, 3'b000,
                           ctl_duplex_r, 8'h00};
      `ANC_A_BMS: rdata = `ANC_BMS_FIXED |
                          {10'h000, state_r == ST_LINK, lp_r[13], 1'b0,
                           link_up_o, 2'b00};
      `ANC_A_ADV: rdata = {7'h00, adv_r, `ANC_SELECTOR};
      `ANC_A_LPA: rdata = lp_r;
      `ANC_A_EXP: rdata = {11'h000, pd_fault_r, lp_r[15] & partner_an_r,
                           `ANC_LOCAL_NP, page_rx_r, partner_an_r};
      `ANC_A_SUM: rdata = {11'h000, state_r == ST_LINK, 1'b0,
                           full_duplex_o, !speed_100_o, link_up_o};
      `ANC_A_PHC: rdata = {mdix_en_r, mdix_force_r, 9'h000, phy_addr_r};
      default:    rdata = 16'h0000;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  forced_strap_a: assert property (
    state_r == ST_LOAD && !negotiate_strap_enable_i |=>
    ctl_speed_r == $past(ability_select_high_i) &&
    ctl_duplex_r == $past(ability_select_low_i) && state_r == ST_FORCED)
    else $error("forced strap not applied");
  adv_strap_a: assert property (
    state_r == ST_LOAD && negotiate_strap_enable_i |=>
    adv_r == $past(strap_adv) ##1 adv_word_o[8:5] == $past(adv_r))
    else $error("strap abilities not loaded");
  prio_pick_a: assert property (
    state_r == ST_ABILITY && aneg_eff && !restart &&
    line_i.page_valid && common != 4'h0 |=>
    res_r == $past(pick) && state_r == ST_LINK)
    else $error("wrong resolution");
  break_quiet_a: assert property (
    restart && aneg_eff && state_r inside {ST_ABILITY, ST_LINK} |=>
    state_r == ST_BREAK ##1 tx_quiet_o && !flp_send_o)
    else $error("restart did not go quiet");
  pd_word_a: assert property (
    $rose(state_r == ST_LINK) && !partner_an_r |->
    lp_r == `ANC_LP_PD100 || lp_r == `ANC_LP_PD10)
    else $error("parallel detect word wrong");
  pd_fault_a: assert property (
    state_r == ST_ABILITY && aneg_eff && pd_bad |=> pd_fault_r)
    else $error("parallel detect fault missed");
  link_loss_a: assert property (
    state_r == ST_LINK && aneg_eff && !restart && !cur_link |=>
    state_r == ST_ABILITY ##1 flp_send_o)
    else $error("link loss did not resume");
  force_swap_a: assert property (
    mdix_force_r |=> mdi_swap_o)
    else $error("forced crossover not applied");
  gate_hold_a: assert property (
    an_block_r |-> state_r == ST_FORCED && !flp_send_o)
    else $error("negotiation ran while gated");
  no_mdix_a: assert property (
    !aneg_eff && !mdix_force_r |=> !mdi_swap_o)
    else $error("crossover active in forced mode");

  cover_pd_c: cover property ($rose(state_r == ST_LINK) && !partner_an_r);
  cover_neg_c: cover property ($rose(state_r == ST_LINK) && partner_an_r);
  cover_brk_c: cover property (state_r == ST_BREAK ##1
                               state_r == ST_ABILITY);
endmodule
`default_nettype wire

// ==== test/anc_lp_model.sv ====
// link partner model driving the receiver status lines of the core
`timescale 1ns/1ps
`default_nettype none
module anc_lp_model
  import anc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // device line activity
  input  wire logic        flp_send_i,
  input  wire logic        tx_quiet_i,
  // setup: 0 negotiating, 1 fixed 100, 2 fixed 10, 3 both receivers
  input  wire logic [1:0]  mode_i,
  input  wire logic [15:0] word_i,
  input  wire logic        link_i,
  // receiver status towards the core
  output var anc_line_s    line_o
);
  logic        sent_r;
  logic        pv_r;
  logic [15:0] pw_r;
  logic        up;
  // the partner drops into link fail while the device stays quiet
  assign up = link_i & ~tx_quiet_i;
  assign line_o = {(mode_i == 2'h0) & ~tx_quiet_i,
                   up & (mode_i != 2'h2), up & (mode_i != 2'h1), pv_r, pw_r};
  // one base page per episode; the word line churns outside the pulse
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sent_r <= 1'b0;
      pv_r <= 1'b0;
      pw_r <= 16'h0000;
    end else begin
      pv_r <= flp_send_i & ~sent_r & (mode_i == 2'h0) & ~tx_quiet_i;
      pw_r <= (flp_send_i & ~sent_r) ? word_i : ~pw_r;
      sent_r <= flp_send_i & (sent_r | (mode_i == 2'h0));
    end
  end
endmodule
`default_nettype wire

// ==== test/anc_core_tb_top.sv ====
// self-checking bench for the negotiation core
`timescale 1ns/1ps
`default_nettype none
module anc_core_tb_top
  import anc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        st_en, st_hi, st_lo, st_mdx, mdc, mdio, lp_link;
  logic        flp, quiet, lup, s100, fdx, swap, mo, moe;
  logic [4:0]  paddr;
  logic [1:0]  lp_mode;
  logic [15:0] lp_word, adv_w;
  anc_line_s   line;
  logic [31:0] seed = 32'h0000_9880;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  anc_core #(.BREAK_CYCLES(20), .MDIX_SLOT(8)) anc_core_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .negotiate_strap_enable_i(st_en),
    .ability_select_high_i(st_hi), .ability_select_low_i(st_lo),
    .mdix_strap_i(st_mdx), .phy_addr_strap_i(paddr), .line_i(line),
    .flp_send_o(flp), .tx_quiet_o(quiet), .adv_word_o(adv_w),
    .link_up_o(lup), .speed_100_o(s100), .full_duplex_o(fdx),
    .mdi_swap_o(swap), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mo),
    .mdio_oe_o(moe));
  anc_lp_model anc_lp_model_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .flp_send_i(flp),
    .tx_quiet_i(quiet), .mode_i(lp_mode), .word_i(lp_word),
    .link_i(lp_link), .line_o(line));
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard, generous against a run of some ten thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // best common ability: 3 100 full, 2 100 half, 1 10 full, 0 10 half
  function automatic int best(int ab);
    for (int i = 3; i >= 0; i--) if (ab[i]) return i;
    return -1;
  endfunction
  task automatic chk_reg(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_pin(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask
  // one management bit: two clocks low, two clocks high
  task automatic mio(logic rd, logic [4:0] ra, logic [15:0] wd,
                     output logic [15:0] q);
    logic [32:0] f;
    f = {3'b101, rd, ~rd, paddr, ra, 2'b10, wd};
    for (int i = 32; i >= 0; i--) begin
      mdc = 1'b0;
      mdio = f[i];
      repeat (2) @(negedge clk_i);
      mdc = 1'b1;
      repeat (2) @(negedge clk_i);
      if (i <= 16 && i >= 1) q[i-1] = moe ? mo : 1'b1; // pulled up
    end
    if (rd) chk_pin("mdio_oe", 1'b0, moe);
    mdc = 1'b0;
    mdio = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    logic [15:0] q;
    mio(1'b0, a, d, q);
  endtask
  task automatic rdc(string n, logic [4:0] a, logic [15:0] m, logic [15:0] e);
    logic [15:0] q;
    mio(1'b1, a, 16'h0000, q);
    chk_reg(n, e & m, q & m);
  endtask
  // reset with given straps, then turn the straps over
  task automatic boot(logic e, logic h, logic l, logic x);
    reset_n_i = 1'b0;
    {st_en, st_hi, st_lo, st_mdx} = {e, h, l, x};
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    {st_en, st_hi, st_lo, st_mdx} = ~{e, h, l, x};
  endtask
  task automatic renego();
    wr(5'h00, 16'h1200);
    repeat (40) @(negedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    int a;
    int b;
    {st_en, st_hi, st_lo, st_mdx, mdc, mdio, lp_link} = 7'h02;
    lp_mode = 2'h0;
    lp_word = 16'h0001;
    paddr = 5'(xs()) | 5'h01;
    for (int s = 7; s >= 0; s--) begin
      boot(s[2], s[1], s[0], s[0] | ~s[1]);
      a = !s[2] ? 15 : s[1:0] == 0 ? 3 : s[1:0] == 1 ? 12 : s[1:0] == 2 ? 5 : 15;
      rdc("adv", 5'h04, 16'h01E0, 16'(a << 5));
      chk_pin("flp", s[2], flp);
      if (!s[2]) begin
        chk_pin("spd", s[1], s100);
        chk_pin("fdx", s[0], fdx);
        chk_pin("swap", 1'b0, swap);
      end
      // straps were turned over after capture
      rdc("phc", 5'h19, 16'h801F, {~st_mdx, 10'h000, paddr});
      if (st_mdx) chk_pin("swap", 1'b0, swap);
    end
    rdc("phc", 5'h19, 16'h801F, {11'h400, paddr});
    wr(5'h00, 16'h1000);
    chk_pin("gated", 1'b0, flp);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h1000);
    chk_pin("quiet", 1'b1, quiet);
    $display("test straps done");
    lp_link = 1'b1;
    for (int n = 0; n < 7; n++) begin
      a = n == 6 ? 15 : int'(xs() & 32'h0000_000F);
      lp_word = n == 6 ? 16'h01E1 : (16'(xs()) & 16'hA1E0) | 16'h0001;
      wr(5'h04, {7'h00, a[3:0], 5'h01});
      wr(5'h00, 16'h1200);
      chk_pin("quiet", 1'b1, quiet);
      chk_pin("flp", 1'b0, flp);
      repeat (40) @(negedge clk_i);
      b = best(a & lp_word[8:5]);
      chk_reg("advw", {7'h00, a[3:0], 5'h01}, adv_w);
      chk_pin("flp", b < 0, flp);
      if (b >= 0) begin
        chk_pin("spd", b[1], s100);
        chk_pin("fdx", b[0], fdx);
        rdc("sum", 5'h10, 16'h0017, {12'h001, 1'b0, b[0], ~b[1], 1'b1});
        rdc("lpa", 5'h05, 16'hFFFF, lp_word);
        rdc("bms", 5'h01, 16'hFFFF, 16'h786D | {lp_word[13], 4'h0});
        rdc("exp", 5'h06, 16'h001F, {12'h000, lp_word[15], 3'b111});
      end
    end
    lp_link = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_pin("flp", 1'b1, flp);
    chk_pin("quiet", 1'b0, quiet);
    lp_link = 1'b1;
    $display("test negotiate done");
    for (int m = 1; m <= 3; m++) begin
      lp_mode = 2'(m);
      renego();
      chk_pin("flp", m == 3, flp);
      if (m < 3) begin
        chk_pin("spd", m == 1, s100);
        chk_pin("fdx", 1'b0, fdx);
        chk_pin("link", 1'b1, lup);
        rdc("lpa", 5'h05, 16'hFFFF, m == 1 ? 16'h0081 : 16'h0021);
        rdc("exp", 5'h06, 16'h0001, 16'h0000);
        rdc("bms", 5'h01, 16'h0020, 16'h0020);
      end else begin
        rdc("exp", 5'h06, 16'h0010, 16'h0010);
      end
    end
    $display("test parallel done");
    for (int c = 0; c < 4; c++) begin
      wr(5'h00, {2'b00, c[1], 4'h0, c[0], 8'h00});
      chk_pin("spd", c[1], s100);
      chk_pin("fdx", c[0], fdx);
      chk_pin("flp", 1'b0, flp);
    end
    wr(5'h19, {11'h200, paddr});
    chk_pin("swap", 1'b1, swap);
    wr(5'h19, {11'h400, paddr});
    chk_pin("swap", 1'b0, swap);
    $display("test forced done");
    complete_run();
  end
endmodule
`default_nettype wire
